/* File: core/rx_overhead_drop_ports.sv */
// Purpose: Receive overhead drop ports: two special purpose serial ports and
//          a 4-bit transport overhead port, each with its own supplied clock
// Assumes: Overhead and special purpose bytes arrive on clk from the framer
// Notes:   Port clocks come from fractional dividers, so single periods jitter
//          by one system cycle while the average rate is exact
module rx_overhead_drop_ports
   import rx_ohd_pkg::*;
(
   // System
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Static configuration pins
   input  wire logic                  toh_valid_active_high,
   input  wire logic                  sp1_valid_active_high,
   input  wire logic                  sp2_valid_active_high,
   input  wire logic                  sp1_clock_gapped,
   input  wire logic                  sp2_clock_gapped,
   // Extracted overhead bytes from the framer
   input  wire logic [`BYTE_W-1:0]    toh_byte_in,
   input  wire logic                  toh_byte_valid,
   input  wire logic                  toh_byte_sof,
   output logic                       toh_byte_ready,
   // Special purpose byte sources
   input  wire logic [`BYTE_W-1:0]    sp1_byte_in,
   input  wire logic                  sp1_byte_valid,
   input  wire logic                  sp1_byte_sof,
   output logic                       sp1_byte_ready,
   input  wire logic [`BYTE_W-1:0]    sp2_byte_in,
   input  wire logic                  sp2_byte_valid,
   input  wire logic                  sp2_byte_sof,
   output logic                       sp2_byte_ready,
   // Transport overhead drop port
   output logic                       toh_drop_clock,
   output logic [`NIBBLE_W-1:0]       toh_drop_nibble,
   output logic                       toh_drop_valid,
   output logic                       toh_drop_frame_pulse,
   // Special purpose drop ports
   output logic                       sp_port1_clock,
   output logic                       sp_port1_serial_out,
   output logic                       sp_port1_valid,
   output logic                       sp_port2_clock,
   output logic                       sp_port2_serial_out,
   output logic                       sp_port2_valid,
   output logic                       sp_frame_pulse
);

   localparam int CFG_W = 5;

   // Configuration pins are asynchronous straps: two flops before use
   // Kept out of reset so the valids leave reset at their idle level
   logic [CFG_W-1:0]        cfg_meta_reg;
   logic [CFG_W-1:0]        cfg_sync_reg;

   always_ff @(posedge clk) begin
      cfg_meta_reg <= {toh_valid_active_high, sp1_valid_active_high,
                       sp2_valid_active_high, sp1_clock_gapped, sp2_clock_gapped};
      cfg_sync_reg <= cfg_meta_reg;
   end

   logic cfg_toh_pol;
   logic cfg_sp1_pol;
   logic cfg_sp2_pol;
   logic cfg_sp1_gap;
   logic cfg_sp2_gap;

   assign cfg_toh_pol = cfg_sync_reg[4];
   assign cfg_sp1_pol = cfg_sync_reg[3];
   assign cfg_sp2_pol = cfg_sync_reg[2];
   assign cfg_sp1_gap = cfg_sync_reg[1];
   assign cfg_sp2_gap = cfg_sync_reg[0];

   // Port clock dividers: phase toggles on each wrap of the accumulator
   logic [`NCO_W-1:0]       toh_acc_reg, toh_acc_next;
   logic                    toh_ph_reg,  toh_ph_next;
   logic [`NCO_W-1:0]       sp_acc_reg,  sp_acc_next;
   logic                    sp_ph_reg,   sp_ph_next;
   logic                    toh_rise, toh_fall;
   logic                    sp_rise,  sp_fall;
   logic [`NCO_W:0]         toh_step, sp_step;

   always_comb begin
      toh_step     = nco_step(toh_acc_reg, toggle_inc(`TOH_CLK_KHZ));
      sp_step      = nco_step(sp_acc_reg, toggle_inc(`SP_CLK_KHZ));
      toh_acc_next = toh_step[`NCO_W-1:0];
      sp_acc_next  = sp_step[`NCO_W-1:0];
      toh_rise     = toh_step[`NCO_W] & ~toh_ph_reg;
      toh_fall     = toh_step[`NCO_W] & toh_ph_reg;
      sp_rise      = sp_step[`NCO_W] & ~sp_ph_reg;
      sp_fall      = sp_step[`NCO_W] & sp_ph_reg;
      toh_ph_next  = toh_ph_reg ^ toh_step[`NCO_W];
      sp_ph_next   = sp_ph_reg ^ sp_step[`NCO_W];
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         toh_acc_reg <= `NCO_RESET;
         toh_ph_reg  <= 1'b0;
         sp_acc_reg  <= `NCO_RESET;
         sp_ph_reg   <= 1'b0;
      end else begin
         toh_acc_reg <= toh_acc_next;
         toh_ph_reg  <= toh_ph_next;
         sp_acc_reg  <= sp_acc_next;
         sp_ph_reg   <= sp_ph_next;
      end
   end

   // Transport overhead port: one byte held, split into two nibbles
   logic [`BYTE_W-1:0]      toh_hold_reg,  toh_hold_next;
   logic                    toh_full_reg,  toh_full_next;
   logic                    toh_sof_reg,   toh_sof_next;
   logic [`NIBBLE_W-1:0]    toh_low_reg,   toh_low_next;
   toh_phase_t              toh_state_reg, toh_state_next;
   logic [`NIBBLE_W-1:0]    toh_nib_reg,   toh_nib_next;
   logic                    toh_vld_reg,   toh_vld_next;
   logic                    toh_fp_reg,    toh_fp_next;
   logic                    toh_rdy_reg,   toh_rdy_next;
   logic                    toh_busy;

   always_comb begin
      toh_hold_next  = toh_hold_reg;
      toh_full_next  = toh_full_reg;
      toh_sof_next   = toh_sof_reg;
      toh_low_next   = toh_low_reg;
      toh_state_next = toh_state_reg;
      toh_nib_next   = toh_nib_reg;
      toh_vld_next   = toh_vld_reg;
      toh_fp_next    = toh_fp_reg;
      toh_busy       = 1'b0;
      if (toh_fall) begin
         // Nibble, valid and frame pulse of the port change only here
         toh_fp_next = 1'b0;
         unique case (toh_state_reg)
            TOH_LOW_NEXT: begin
               toh_nib_next   = toh_low_reg;
               toh_state_next = TOH_HIGH_NEXT;
               toh_busy       = 1'b1;
            end
            TOH_HIGH_NEXT: begin
               if (toh_full_reg) begin
                  // Bytes leave in the order taken
                  toh_nib_next   = toh_hold_reg[`BYTE_HI_MSB:`BYTE_HI_LSB];
                  toh_low_next   = toh_hold_reg[`NIBBLE_W-1:0];
                  toh_fp_next    = toh_sof_reg;
                  toh_full_next  = 1'b0;
                  toh_state_next = TOH_LOW_NEXT;
                  toh_busy       = 1'b1;
               end
            end
         endcase
         toh_vld_next = cfg_toh_pol ? toh_busy : ~toh_busy;
      end
      // Refill after the byte has left; the framer waits on ready
      if (toh_byte_valid && toh_rdy_reg) begin
         toh_hold_next = toh_byte_in;
         toh_sof_next  = toh_byte_sof;
         toh_full_next = 1'b1;
      end
      toh_rdy_next = ~toh_full_next;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         toh_hold_reg  <= `BYTE_RESET;
         toh_full_reg  <= 1'b0;
         toh_sof_reg   <= 1'b0;
         toh_low_reg   <= `NIBBLE_RESET;
         toh_state_reg <= TOH_HIGH_NEXT;
         toh_nib_reg   <= `NIBBLE_RESET;
         toh_vld_reg   <= ~cfg_toh_pol;
         toh_fp_reg    <= 1'b0;
         toh_rdy_reg   <= 1'b0;
      end else begin
         toh_hold_reg  <= toh_hold_next;
         toh_full_reg  <= toh_full_next;
         toh_sof_reg   <= toh_sof_next;
         toh_low_reg   <= toh_low_next;
         toh_state_reg <= toh_state_next;
         toh_nib_reg   <= toh_nib_next;
         toh_vld_reg   <= toh_vld_next;
         toh_fp_reg    <= toh_fp_next;
         toh_rdy_reg   <= toh_rdy_next;
      end
   end

   // Special purpose ports share one phase so one frame pulse serves both
   logic sp1_first;
   logic sp2_first;

   sp_serial_port u_sp1 (
      .clk               (clk),
      .rst               (rst),
      .rise_en           (sp_rise),
      .fall_en           (sp_fall),
      .valid_active_high (cfg_sp1_pol),
      .clock_gapped      (cfg_sp1_gap),
      .byte_in           (sp1_byte_in),
      .byte_valid        (sp1_byte_valid),
      .byte_sof          (sp1_byte_sof),
      .byte_ready        (sp1_byte_ready),
      .port_clock        (sp_port1_clock),
      .serial_out        (sp_port1_serial_out),
      .valid_out         (sp_port1_valid),
      .first_bit_next    (sp1_first)
   );

   sp_serial_port u_sp2 (
      .clk               (clk),
      .rst               (rst),
      .rise_en           (sp_rise),
      .fall_en           (sp_fall),
      .valid_active_high (cfg_sp2_pol),
      .clock_gapped      (cfg_sp2_gap),
      .byte_in           (sp2_byte_in),
      .byte_valid        (sp2_byte_valid),
      .byte_sof          (sp2_byte_sof),
      .byte_ready        (sp2_byte_ready),
      .port_clock        (sp_port2_clock),
      .serial_out        (sp_port2_serial_out),
      .valid_out         (sp_port2_valid),
      .first_bit_next    (sp2_first)
   );

   logic sp_fp_reg, sp_fp_next;

   always_comb begin
      sp_fp_next = sp_fp_reg;
      if (sp_fall) begin
         sp_fp_next = sp1_first | sp2_first;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         sp_fp_reg <= 1'b0;
      end else begin
         sp_fp_reg <= sp_fp_next;
      end
   end

   assign toh_byte_ready       = toh_rdy_reg;
   assign toh_drop_clock       = toh_ph_reg;
   assign toh_drop_nibble      = toh_nib_reg;
   assign toh_drop_valid       = toh_vld_reg;
   assign toh_drop_frame_pulse = toh_fp_reg;
   assign sp_frame_pulse       = sp_fp_reg;

endmodule

/* File: core/rx_ohd_map.svh */
// Purpose: Constants for the receive overhead drop ports
// Assumes: System clock of 100 MHz; port clocks made by fractional dividers
// Notes:   Rates in kHz so the divider ratios stay exact
`ifndef RX_OHD_MAP_SVH
`define RX_OHD_MAP_SVH

// Timing
`define SYS_CLK_KHZ     17'h186A0
`define TOH_CLK_KHZ     17'h097E0
`define SP_CLK_KHZ      17'h00870
`define NCO_W           17

// Field layout
`define BYTE_W          8
`define NIBBLE_W        4
`define BYTE_HI_MSB     7
`define BYTE_HI_LSB     4
`define BIT_COUNT_W     3
`define BITS_AFTER_MSB  3'h7

// Reset values
`define BYTE_RESET      8'h00
`define NIBBLE_RESET    4'h0
`define NCO_RESET       17'h00000

`endif

/* File: core/rx_ohd_pkg.sv */
// Purpose: Types and shared arithmetic for the receive overhead drop ports
// Assumes: rx_ohd_map.svh supplies every number
// Notes:   The divider step is shared by the overhead and special purpose clocks
`include "rx_ohd_map.svh"

package rx_ohd_pkg;

   typedef enum logic {
      TOH_HIGH_NEXT,
      TOH_LOW_NEXT
   } toh_phase_t;

   // One step of a fractional divider: returns {wrap, new accumulator}
   function automatic logic [`NCO_W:0] nco_step(input logic [`NCO_W-1:0] acc,
                                                 input logic [`NCO_W-1:0] inc);
      logic [`NCO_W:0] sum;
      sum = {1'b0, acc} + {1'b0, inc};
      if (sum >= {1'b0, `SYS_CLK_KHZ}) begin
         sum = sum - {1'b0, `SYS_CLK_KHZ};
         nco_step = {1'b1, sum[`NCO_W-1:0]};
      end else begin
         nco_step = {1'b0, sum[`NCO_W-1:0]};
      end
   endfunction

   // Toggle increment: two toggles per output period
   function automatic logic [`NCO_W-1:0] toggle_inc(input logic [`NCO_W-1:0] khz);
      toggle_inc = {khz[`NCO_W-2:0], 1'b0};
   endfunction

endpackage

/* File: core/sp_serial_port.sv */
// Purpose: One receive special purpose serial output port
// Assumes: rise_en and fall_en are one-cycle pulses of the shared port clock phase;
//          valid_active_high has settled while rst is held
// Notes:   One byte of holding keeps the serial stream seamless across bytes
module sp_serial_port
   import rx_ohd_pkg::*;
(
   // System
   input  wire logic                  clk,
   input  wire logic                  rst,
   // Port clock phase events
   input  wire logic                  rise_en,
   input  wire logic                  fall_en,
   // Configuration
   input  wire logic                  valid_active_high,
   input  wire logic                  clock_gapped,
   // Byte source
   input  wire logic [`BYTE_W-1:0]    byte_in,
   input  wire logic                  byte_valid,
   input  wire logic                  byte_sof,
   output logic                       byte_ready,
   // Serial side
   output logic                       port_clock,
   output logic                       serial_out,
   output logic                       valid_out,
   output logic                       first_bit_next
);

   logic [`BYTE_W-1:0]      hold_reg,  hold_next;
   logic                    full_reg,  full_next;
   logic                    sof_reg,   sof_next;
   logic [`BYTE_W-1:0]      shift_reg, shift_next;
   logic [`BIT_COUNT_W-1:0] cnt_reg,   cnt_next;
   logic                    busy_reg,  busy_next;
   logic                    bit_reg,   bit_next;
   logic                    vout_reg,  vout_next;
   logic                    pclk_reg,  pclk_next;
   logic                    rdy_reg,   rdy_next;

   always_comb begin
      hold_next      = hold_reg;
      full_next      = full_reg;
      sof_next       = sof_reg;
      shift_next     = shift_reg;
      cnt_next       = cnt_reg;
      busy_next      = busy_reg;
      bit_next       = bit_reg;
      vout_next      = vout_reg;
      pclk_next      = pclk_reg;
      first_bit_next = 1'b0;
      if (fall_en) begin
         // Data and qualifier move only as the port clock falls
         pclk_next = 1'b0;
         if (busy_reg && cnt_reg != '0) begin
            bit_next   = shift_reg[`BYTE_W-1];
            shift_next = {shift_reg[`BYTE_W-2:0], 1'b0};
            cnt_next   = cnt_reg - 1'b1;
         end else if (full_reg) begin
            bit_next       = hold_reg[`BYTE_W-1];
            shift_next     = {hold_reg[`BYTE_W-2:0], 1'b0};
            cnt_next       = `BITS_AFTER_MSB;
            busy_next      = 1'b1;
            full_next      = 1'b0;
            first_bit_next = sof_reg;
         end else begin
            busy_next = 1'b0;
         end
         // Qualifier at the selected level while a bit is out
         vout_next = valid_active_high ? busy_next : ~busy_next;
      end else if (rise_en) begin
         // Gapped mode drops the pulse when no bit is out
         pclk_next = ~clock_gapped | busy_reg;
      end
      if (byte_valid && rdy_reg) begin
         hold_next = byte_in;
         sof_next  = byte_sof;
         full_next = 1'b1;
      end
      rdy_next = ~full_next;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         hold_reg  <= `BYTE_RESET;
         full_reg  <= 1'b0;
         sof_reg   <= 1'b0;
         shift_reg <= `BYTE_RESET;
         cnt_reg   <= '0;
         busy_reg  <= 1'b0;
         bit_reg   <= 1'b0;
         vout_reg  <= ~valid_active_high;
         pclk_reg  <= 1'b0;
         rdy_reg   <= 1'b0;
      end else begin
         hold_reg  <= hold_next;
         full_reg  <= full_next;
         sof_reg   <= sof_next;
         shift_reg <= shift_next;
         cnt_reg   <= cnt_next;
         busy_reg  <= busy_next;
         bit_reg   <= bit_next;
         vout_reg  <= vout_next;
         pclk_reg  <= pclk_next;
         rdy_reg   <= rdy_next;
      end
   end

   assign byte_ready = rdy_reg;
   assign port_clock = pclk_reg;
   assign serial_out = bit_reg;
   assign valid_out  = vout_reg;

endmodule

/* File: verification/rx_ohd_chk.sv */
// Purpose: Port checks of the receive overhead drop ports
// Assumes: Straps steady outside reset
// Notes:   Special port edge checks only in continuous clock mode
`include "rx_ohd_map.svh"
module rx_ohd_chk
   import rx_ohd_pkg::*;
(
   // System
   input  wire logic                clk,
   input  wire logic                rst,
   // Straps
   input  wire logic                sp1_valid_active_high,
   input  wire logic                sp1_clock_gapped,
   input  wire logic                sp2_clock_gapped,
   // Overhead port
   input  wire logic                toh_drop_clock,
   input  wire logic [`NIBBLE_W-1:0] toh_drop_nibble,
   input  wire logic                toh_drop_valid,
   input  wire logic                toh_drop_frame_pulse,
   // Special ports
   input  wire logic                sp_port1_clock,
   input  wire logic                sp_port1_serial_out,
   input  wire logic                sp_port1_valid,
   input  wire logic                sp_port2_clock,
   input  wire logic                sp_port2_serial_out,
   input  wire logic                sp_frame_pulse
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] up_cnt;
   logic [5:0] hi_cnt;
   // The overhead clock half period check waits out the divider start after reset
   always_ff @(posedge clk) begin
      if (rst) begin
         up_cnt <= 3'h0;
         hi_cnt <= 6'h00;
      end else begin
         up_cnt <= (up_cnt == 3'h7) ? up_cnt : up_cnt + 3'h1;
         hi_cnt <= sp_port1_clock ? hi_cnt + 6'h01 : 6'h00;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   toh_nib_edge_a: assert property (
      $changed(toh_drop_nibble) |-> $fell(toh_drop_clock)) else $error("nibble moved off fall");
   toh_valid_edge_a: assert property (
      $changed(toh_drop_valid) |-> $fell(toh_drop_clock)) else $error("valid moved off fall");
   toh_fp_edge_a: assert property (
      $changed(toh_drop_frame_pulse) |-> $fell(toh_drop_clock)) else $error("pulse off fall");
   toh_fp_width_a: assert property (
      $fell(toh_drop_clock) && !$rose(toh_drop_frame_pulse) |-> !toh_drop_frame_pulse)
      else $error("overhead pulse too long");
   toh_half_max_a: assert property (
      up_cnt == 3'h7 && $stable(toh_drop_clock) |-> ##1 $changed(toh_drop_clock))
      else $error("overhead clock half period too long");
   sp1_data_edge_a: assert property (
      !sp1_clock_gapped && $changed(sp_port1_serial_out) |-> $fell(sp_port1_clock))
      else $error("port 1 data off fall");
   sp2_data_edge_a: assert property (
      !sp2_clock_gapped && $changed(sp_port2_serial_out) |-> $fell(sp_port2_clock))
      else $error("port 2 data off fall");
   sp1_valid_edge_a: assert property (
      !sp1_clock_gapped && $changed(sp_port1_valid) |-> $fell(sp_port1_clock))
      else $error("port 1 valid off fall");
   sp_fp_edge_a: assert property (
      !sp1_clock_gapped && $changed(sp_frame_pulse) |-> $fell(sp_port1_clock))
      else $error("shared pulse off fall");
   sp1_high_len_a: assert property (
      $fell(sp_port1_clock) |-> hi_cnt >= 6'h17 && hi_cnt <= 6'h18)
      else $error("port 1 high time off");
   sp_gap_rise_a: assert property (
      sp1_clock_gapped && $rose(sp_port1_clock) |-> sp_port1_valid == sp1_valid_active_high)
      else $error("gapped clock pulse without data");
   cover property ($rose(toh_drop_frame_pulse));
   cover property ($rose(sp_frame_pulse));
   cover property (sp1_clock_gapped && $rose(sp_port1_clock));
endmodule

bind rx_overhead_drop_ports rx_ohd_chk rx_ohd_chk_i (.clk, .rst, .sp1_valid_active_high,
   .sp1_clock_gapped, .sp2_clock_gapped, .toh_drop_clock, .toh_drop_nibble, .toh_drop_valid,
   .toh_drop_frame_pulse, .sp_port1_clock, .sp_port1_serial_out, .sp_port1_valid,
   .sp_port2_clock, .sp_port2_serial_out, .sp_frame_pulse);

/* File: verification/rx_ohd_sink.sv */
// Purpose: Overhead processing logic fed by the drop ports
// Assumes: Supplied clocks are slow enough to be sampled by clk
// Notes:   Frame pulse is logged per unit so its width shows in the bytes
module rx_ohd_sink (
   // System
   input  wire logic       clk,
   input  wire logic       rst,
   // Configured active levels
   input  wire logic       toh_pol,
   input  wire logic       sp1_pol,
   input  wire logic       sp2_pol,
   // Watched ports
   input  wire logic       toh_drop_clock,
   input  wire logic [3:0] toh_drop_nibble,
   input  wire logic       toh_drop_valid,
   input  wire logic       toh_drop_frame_pulse,
   input  wire logic       sp_port1_clock,
   input  wire logic       sp_port1_serial_out,
   input  wire logic       sp_port1_valid,
   input  wire logic       sp_port2_clock,
   input  wire logic       sp_port2_serial_out,
   input  wire logic       sp_port2_valid,
   input  wire logic       sp_frame_pulse,
   // Assembled units
   output logic [7:0]      toh_byte,
   output logic [7:0]      toh_fp,
   output logic            toh_stb,
   output logic [7:0]      sp1_byte,
   output logic [7:0]      sp1_fp,
   output logic            sp1_stb,
   output logic [7:0]      sp2_byte,
   output logic            sp2_stb
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       tc_q, c1_q, c2_q, half;
   logic [3:0] hi;
   logic [2:0] n1, n2;
   always @(posedge clk) begin
      toh_stb <= 1'b0;
      sp1_stb <= 1'b0;
      sp2_stb <= 1'b0;
      tc_q <= toh_drop_clock;
      c1_q <= sp_port1_clock;
      c2_q <= sp_port2_clock;
      if (rst) begin
         half <= 1'b0;
         n1 <= 3'h0;
         n2 <= 3'h0;
      end else begin
         // Capture on the supplied clock rise, only while valid is active
         if (toh_drop_clock && !tc_q && toh_drop_valid == toh_pol) begin
            if (toh_drop_frame_pulse || !half) begin
               hi <= toh_drop_nibble;
               toh_fp <= {6'h00, toh_drop_frame_pulse, 1'b0};
               half <= 1'b1;
            end else begin
               toh_byte <= {hi, toh_drop_nibble};
               toh_fp[0] <= toh_drop_frame_pulse;
               toh_stb <= 1'b1;
               half <= 1'b0;
            end
         end
         if (sp_port1_clock && !c1_q && sp_port1_valid == sp1_pol) begin
            sp1_byte <= {sp1_byte[6:0], sp_port1_serial_out};
            sp1_fp <= {sp1_fp[6:0], sp_frame_pulse};
            n1 <= n1 + 3'h1;
            sp1_stb <= (n1 == 3'h7);
         end
         if (sp_port2_clock && !c2_q && sp_port2_valid == sp2_pol) begin
            sp2_byte <= {sp2_byte[6:0], sp_port2_serial_out};
            n2 <= n2 + 3'h1;
            sp2_stb <= (n2 == 3'h7);
         end
      end
   end
endmodule

/* File: verification/rx_overhead_drop_ports_bench.sv */
// Purpose: Self-checking bench of the receive overhead drop ports
// Assumes: Sources offer random bytes with random idle gaps
// Notes:   Two phases swap polarities and gapping; rates measured while idle
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_errors++; $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module rx_overhead_drop_ports_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic       clk, rst, toh_pol, sp1_pol, sp2_pol, g1, g2, pc0, pc1, pc2, done;
   logic [7:0] sd [3];
   logic       sv [3], ss [3], took [3], rdy [3];
   logic       tck, c1, c2, tv, v1, v2, tfp, d1, d2, sfp, tstb, s1stb, s2stb;
   logic [3:0] nib;
   logic [7:0] tbyte, tfpv, s1byte, s1fp, s2byte;
   int         seed, n_errors, num_checks, i, r0, r1, r2, cont, gap;
   int         nleft [3], cnt [3];
   int         exp_q [3][$];
   rx_overhead_drop_ports rx_overhead_drop_ports_i (.clk, .rst,
      .toh_valid_active_high(toh_pol), .sp1_valid_active_high(sp1_pol),
      .sp2_valid_active_high(sp2_pol), .sp1_clock_gapped(g1), .sp2_clock_gapped(g2),
      .toh_byte_in(sd[0]), .toh_byte_valid(sv[0]), .toh_byte_sof(ss[0]), .toh_byte_ready(rdy[0]),
      .sp1_byte_in(sd[1]), .sp1_byte_valid(sv[1]), .sp1_byte_sof(ss[1]), .sp1_byte_ready(rdy[1]),
      .sp2_byte_in(sd[2]), .sp2_byte_valid(sv[2]), .sp2_byte_sof(ss[2]), .sp2_byte_ready(rdy[2]),
      .toh_drop_clock(tck), .toh_drop_nibble(nib), .toh_drop_valid(tv),
      .toh_drop_frame_pulse(tfp), .sp_port1_clock(c1), .sp_port1_serial_out(d1),
      .sp_port1_valid(v1), .sp_port2_clock(c2), .sp_port2_serial_out(d2),
      .sp_port2_valid(v2), .sp_frame_pulse(sfp));
   rx_ohd_sink rx_ohd_sink_i (.clk, .rst, .toh_pol, .sp1_pol, .sp2_pol,
      .toh_drop_clock(tck), .toh_drop_nibble(nib), .toh_drop_valid(tv),
      .toh_drop_frame_pulse(tfp), .sp_port1_clock(c1), .sp_port1_serial_out(d1),
      .sp_port1_valid(v1), .sp_port2_clock(c2), .sp_port2_serial_out(d2),
      .sp_port2_valid(v2), .sp_frame_pulse(sfp), .toh_byte(tbyte), .toh_fp(tfpv),
      .toh_stb(tstb), .sp1_byte(s1byte), .sp1_fp(s1fp), .sp1_stb(s1stb),
      .sp2_byte(s2byte), .sp2_stb(s2stb));
   always #5 clk = ~clk;
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic take(input int s, input logic [7:0] got, input logic [7:0] fpv,
                       input logic [7:0] mark);
      int v;
      v = exp_q[s].pop_front();
      `CHK(got, v[7:0])
      `CHK(fpv, v[8] ? mark : 8'h00)
   endtask
   always @(posedge clk) for (int s = 0; s < 3; s++) took[s] <= sv[s] && rdy[s];
   // Feeder holds each offer until taken, with random idle between offers
   always @(negedge clk) begin
      for (int s = 0; s < 3; s++) begin
         if (took[s] || !sv[s]) begin
            if (nleft[s] > 0 && ($random(seed) & 3) != 0) begin
               sd[s] = 8'($random(seed));
               ss[s] = (cnt[s] % 20 == 0) && (s != 2);
               sv[s] = 1'b1;
               exp_q[s].push_back({23'h0, ss[s], sd[s]});
               cnt[s]++;
               nleft[s]--;
            end else begin
               sv[s] = 1'b0;
            end
         end
      end
      if (tstb) take(0, tbyte, tfpv, 8'h02);
      if (s1stb) take(1, s1byte, s1fp, 8'h80);
      if (s2stb) take(2, s2byte, 8'h00, 8'h80);
   end
   initial begin
      seed = 32'h53B80DE6;
      clk = 1'b0;
      rst = 1'b1;
      n_errors = 0;
      num_checks = 0;
      {toh_pol, sp1_pol, sp2_pol, g1, g2} = 5'h00;
      for (int s = 0; s < 3; s++) begin
         {sd[s], sv[s], ss[s], nleft[s]} = '0;
      end
      for (int p = 0; p < 2; p++) begin
         {toh_pol, sp1_pol, sp2_pol, g1, g2} = {p[0], !p[0], p[0], p[0], !p[0]};
         rst = 1'b1;
         repeat (4) @(negedge clk);
         rst = 1'b0;
         nleft = '{40, 4, 4};
         cnt = '{0, 0, 0};
         done = 1'b0;
         for (i = 0; i < 30000 && !done; i++) begin
            @(negedge clk);
            done = nleft.sum() == 0 && !sv[0] && !sv[1] && !sv[2] && exp_q[0].size() == 0
                   && exp_q[1].size() == 0 && exp_q[2].size() == 0;
         end
         if (!done) begin
            n_errors++;
            stop_test();
         end
         // Settle margin for the last special bit period
         repeat (60) @(negedge clk);
         `CHK(tv, !toh_pol)
         `CHK(v1, !sp1_pol)
         `CHK(v2, !sp2_pol)
         {r0, r1, r2, pc0, pc1, pc2} = '0;
         for (i = 0; i < 10000; i++) begin
            @(negedge clk);
            r0 += int'(tck && !pc0);
            r1 += int'(c1 && !pc1);
            r2 += int'(c2 && !pc2);
            {pc0, pc1, pc2} = {tck, c1, c2};
         end
         cont = g1 ? r2 : r1;
         gap = g1 ? r1 : r2;
         `CHK(r0 >= 3887 && r0 <= 3889, 1'b1)
         `CHK(cont >= 215 && cont <= 217, 1'b1)
         `CHK(gap, 0)
      end
      stop_test();
   end
endmodule
